// ==== rtl/cat_timer_control.sv ====
// control, status and interrupt logic of the counter array timer, APB slave
// assumes a 32-bit APB master on CLK_SYS; capture pulses come from outside datapaths
//
// Summary of operation
// R1 - counter rollover sets overflow flag bit 7
// R2 - overflow flag and enable raise request
// R3 - software sets or clears overflow flag
// R4 - run bit 6 gates counting
// R5 - match or capture sets module flag
// R6 - module flag and enable raise request
// R7 - software clears module flags itself
// R8 - low byte carry increments high byte
// R9 - counter bytes exposed in two registers
// R10 - match enable compares counter with module
// R11 - mode bit 0 enables module interrupt
// R12 - wrap to zero, flag, keep running
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module cat_timer_control
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [cat_pkg::ADDR_WIDTH-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [cat_pkg::NUM_MODULES-1:0] MODULE_CAPTURE,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic OVF_IRQ_REQ,
    output logic [cat_pkg::NUM_MODULES-1:0] MODULE_IRQ_REQ,
    output logic IRQ
);
    import cat_pkg::*;

    // ****************************************
    // bus decode
    // ****************************************
    logic [7:0] idx;
    logic idx_high_zero;
    logic access;
    logic commit;
    logic wr;
    logic lane0;
    logic [7:0] wbyte;
    logic mapped;
    logic hit_control;
    logic hit_mode;
    logic hit_low;
    logic hit_high;
    logic hit_status;
    logic hit_mask;
    logic [NUM_MODULES-1:0] hit_mm;
    logic [NUM_MODULES-1:0] hit_cl;
    logic [NUM_MODULES-1:0] hit_ch;

    always_comb
    begin
        idx = PADDR[IDX_MSB:IDX_LSB];
        idx_high_zero = (PADDR[ADDR_WIDTH-1:IDX_MSB+1] == 2'b00);
        access = PSEL & PENABLE;
        commit = access & PREADY;
        lane0 = PSTRB[0];
        wr = commit & PWRITE & lane0;
        wbyte = PWDATA[7:0];
        hit_control = idx_high_zero & (idx == IDX_CONTROL);
        hit_mode = idx_high_zero & (idx == IDX_ARRAY_MODE);
        hit_low = idx_high_zero & (idx == IDX_COUNT_LOW);
        hit_high = idx_high_zero & (idx == IDX_COUNT_HIGH);
        hit_status = idx_high_zero & (idx == IDX_IRQ_STATUS);
        hit_mask = idx_high_zero & (idx == IDX_IRQ_MASK);
    end

    // ****************************************
    // state
    // ****************************************
    logic overflow_flag;
    logic counter_run;
    logic [NUM_MODULES-1:0] module_event_flags;
    logic overflow_irq_enable;
    logic [7:0] module_mode_register [NUM_MODULES];
    logic [15:0] compare_value [NUM_MODULES];
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [NUM_MODULES-1:0] module_set;
    logic [NUM_MODULES-1:0] module_irq_enable;
    logic [NUM_MODULES-1:0] match_function_enable;
    logic [IRQ_WIDTH-1:0] irq_events;
    cat_count_type cnt;

    cat_counter u_counter
    (
        .clk(CLK_SYS),
        .nrst(NRST),
        .run(counter_run),
        .load_low(wr & hit_low),
        .load_high(wr & hit_high),
        .load_data(wbyte),
        .status(cnt)
    );

    // ****************************************
    // per-module decode and event detect
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < NUM_MODULES; gi++)
        begin : g_module
            localparam logic [7:0] OFS = 8'(gi);
            assign hit_mm[gi] = idx_high_zero & (idx == IDX_MODULE_MODE0 + OFS);
            assign hit_cl[gi] = idx_high_zero & (idx == IDX_COMPARE_LOW0 + OFS);
            assign hit_ch[gi] = idx_high_zero & (idx == IDX_COMPARE_HIGH0 + OFS);
            assign module_irq_enable[gi] = module_mode_register[gi][MM_IRQ_ENABLE_BIT]; // R11
            assign match_function_enable[gi] = module_mode_register[gi][MM_MATCH_BIT];
            // only freshly advanced counts match, so a halted counter flags once
            assign module_set[gi] = MODULE_CAPTURE[gi]
                | (cnt.tick & match_function_enable[gi]
                   & module_mode_register[gi][MM_COMPARE_BIT]
                   & (cnt.count == compare_value[gi])); // R5 R10

            always_ff @(posedge CLK_SYS)
            begin
                if (!NRST)
                    module_mode_register[gi] <= BYTE_RESET;
                else if (wr && hit_mm[gi])
                    module_mode_register[gi] <= wbyte & ~(BYTE_ONE << MM_RESERVED_BIT);
            end

            always_ff @(posedge CLK_SYS)
            begin
                if (!NRST)
                    compare_value[gi] <= COMPARE_RESET;
                else if (wr && hit_cl[gi])
                    compare_value[gi][7:0] <= wbyte;
                else if (wr && hit_ch[gi])
                    compare_value[gi][15:8] <= wbyte;
            end
        end
    endgenerate

    always_comb
    begin
        mapped = hit_control | hit_mode | hit_low | hit_high | hit_status | hit_mask
            | (|hit_mm) | (|hit_cl) | (|hit_ch);
        irq_events = {module_set, cnt.wrap};
    end

    // ****************************************
    // control and status register
    // ****************************************
    // hardware set wins over a software write in the same cycle
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            overflow_flag <= CONTROL_RESET[CTL_OVERFLOW_BIT];
        else if (cnt.wrap)
            overflow_flag <= 1'b1; // R1 R12
        else if (wr && hit_control)
            overflow_flag <= wbyte[CTL_OVERFLOW_BIT]; // R3
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            counter_run <= CONTROL_RESET[CTL_RUN_BIT];
        else if (wr && hit_control)
            counter_run <= wbyte[CTL_RUN_BIT]; // R4
    end

    // flags stay set until software writes zeros
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            module_event_flags <= CONTROL_RESET[NUM_MODULES-1:0];
        else if (wr && hit_control)
            module_event_flags <= wbyte[NUM_MODULES-1:0] | module_set; // R7
        else
            module_event_flags <= module_event_flags | module_set; // R5
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            overflow_irq_enable <= BYTE_RESET[MODE_OVF_IE_BIT];
        else if (wr && hit_mode)
            overflow_irq_enable <= wbyte[MODE_OVF_IE_BIT];
    end

    // ****************************************
    // interrupt requests
    // ****************************************
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            OVF_IRQ_REQ <= 1'b0;
        else
            OVF_IRQ_REQ <= overflow_flag & overflow_irq_enable; // R2
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            MODULE_IRQ_REQ <= '0;
        else
            MODULE_IRQ_REQ <= module_event_flags & module_irq_enable; // R6
    end

    // sticky event log, write one to clear, new events win
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            irq_status <= IRQ_RESET;
        else if (wr && hit_status)
            irq_status <= (irq_status & ~wbyte[IRQ_WIDTH-1:0]) | irq_events;
        else
            irq_status <= irq_status | irq_events;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            irq_mask <= IRQ_RESET;
        else if (wr && hit_mask)
            irq_mask <= wbyte[IRQ_WIDTH-1:0];
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            IRQ <= 1'b0;
        else
            IRQ <= |(irq_status & irq_mask);
    end

    // ****************************************
    // apb answer
    // ****************************************
    logic [7:0] rbyte;
    integer k;

    always_comb
    begin
        rbyte = BYTE_RESET;
        if (hit_control)
            rbyte = {overflow_flag, counter_run, 1'b0, module_event_flags};
        if (hit_mode)
            rbyte = {7'h00, overflow_irq_enable};
        if (hit_low)
            rbyte = cnt.count[7:0]; // R9
        if (hit_high)
            rbyte = cnt.count[15:8]; // R9
        if (hit_status)
            rbyte = {2'b00, irq_status};
        if (hit_mask)
            rbyte = {2'b00, irq_mask};
        for (k = 0; k < NUM_MODULES; k++)
        begin
            if (hit_mm[k])
                rbyte = module_mode_register[k];
            if (hit_cl[k])
                rbyte = compare_value[k][7:0];
            if (hit_ch[k])
                rbyte = compare_value[k][15:8];
        end
    end

    // one wait state keeps every answer signal straight from a flop
    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            PREADY <= 1'b0;
        else
            PREADY <= access & ~PREADY;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            PSLVERR <= 1'b0;
        else
            PSLVERR <= access & ~PREADY & ~mapped;
    end

    always_ff @(posedge CLK_SYS)
    begin
        if (!NRST)
            PRDATA <= RDATA_RESET;
        else if (access && !PREADY && !PWRITE)
            PRDATA <= {24'h00_0000, rbyte};
        else if (commit)
            PRDATA <= RDATA_RESET;
    end

endmodule

// ==== rtl/cat_pkg.sv ====
// constants, register indices and carrier types of the counter array timer control
// assumes a 32-bit APB master; byte address of a register is four times its index
package cat_pkg;

    // ****************************************
    // register indices
    // ****************************************
    localparam logic [7:0] IDX_CONTROL = 8'hd8;
    localparam logic [7:0] IDX_ARRAY_MODE = 8'hc0;
    localparam logic [7:0] IDX_COUNT_LOW = 8'he9;
    localparam logic [7:0] IDX_COUNT_HIGH = 8'hf9;
    localparam logic [7:0] IDX_MODULE_MODE0 = 8'hda;
    localparam logic [7:0] IDX_COMPARE_LOW0 = 8'hea;
    localparam logic [7:0] IDX_COMPARE_HIGH0 = 8'hfa;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hc1;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hc2;

    localparam int NUM_MODULES = 5;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int ADDR_WIDTH = 12;

    // ****************************************
    // field positions
    // ****************************************
    localparam int CTL_OVERFLOW_BIT = 7;
    localparam int CTL_RUN_BIT = 6;
    localparam int MODE_OVF_IE_BIT = 0;
    localparam int MM_IRQ_ENABLE_BIT = 0;
    localparam int MM_MATCH_BIT = 3;
    localparam int MM_COMPARE_BIT = 6;
    localparam int MM_RESERVED_BIT = 7;
    localparam int IRQ_OVERFLOW_BIT = 0;
    localparam int IRQ_MODULE_LSB = 1;
    localparam int IRQ_WIDTH = 6;

    // ****************************************
    // reset values and byte constants
    // ****************************************
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [5:0] IRQ_RESET = 6'h00;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [7:0] BYTE_ONE = 8'h01;

    typedef struct packed {
        logic [15:0] count;
        logic wrap;
        logic tick;
    } cat_count_type;

endpackage

// ==== rtl/cat_counter.sv ====
// cascaded low/high byte timer counter with software loads
// assumes loads come from the register slave, one byte at a time
`timescale 1ns/1ps
module cat_counter
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic run,
    input wire logic load_low,
    input wire logic load_high,
    input wire logic [7:0] load_data,
    output cat_pkg::cat_count_type status
);
    import cat_pkg::*;

    logic [7:0] low;
    logic [7:0] high;
    logic tick;
    logic advance;
    logic carry;

    // a load in the same cycle beats counting, so software sees its byte
    always_comb
    begin
        advance = run & ~load_low & ~load_high; // R4
        carry = (low == BYTE_ONES); // R8
        status.count = {high, low}; // R9
        status.wrap = advance & carry & (high == BYTE_ONES); // R12
        status.tick = tick;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            low <= BYTE_RESET;
        else if (load_low)
            low <= load_data;
        else if (advance)
            low <= low + BYTE_ONE; // R12
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            high <= BYTE_RESET;
        else if (load_high)
            high <= load_data;
        else if (advance && carry)
            high <= high + BYTE_ONE; // R8
    end

    // marks the cycle in which count holds a freshly advanced value
    always_ff @(posedge clk)
    begin
        if (!nrst)
            tick <= 1'b0;
        else
            tick <= advance;
    end

endmodule

// ==== bench/cat_timer_control_sva.sv ====
// checker of the apb answer and interrupt request outputs
// assumes a bind onto cat_timer_control, one clock domain
`timescale 1ns/1ps
module cat_timer_control_sva
(
    input wire logic CLK_SYS,
    input wire logic NRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic OVF_IRQ_REQ,
    input wire logic [cat_pkg::NUM_MODULES-1:0] MODULE_IRQ_REQ,
    input wire logic IRQ
);
    import cat_pkg::*;

    // ****
    // properties
    // ****
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!NRST);
    logic wr;
    assign wr = PSEL && PWRITE;
    // flags drop only through a software write, two cycles of lag
    property p_ovf_hold;
        OVF_IRQ_REQ && !wr && !$past(wr) |=> OVF_IRQ_REQ;
    endproperty
    a_ovf_hold: assert property (p_ovf_hold) else $error("ovf req dropped");
    property p_mod_hold;
        !wr && !$past(wr) |=> (MODULE_IRQ_REQ & $past(MODULE_IRQ_REQ)) == $past(MODULE_IRQ_REQ);
    endproperty
    a_mod_hold: assert property (p_mod_hold) else $error("module req dropped");
    property p_ready_wait;
        PSEL && PENABLE && !$past(PENABLE) |-> !PREADY ##1 PREADY;
    endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("ready not after one wait");
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
    property p_ready_access;
        PREADY |-> PSEL && PENABLE;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    property p_err_ready;
        PSLVERR |-> PREADY;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_rdata_idle;
        !PREADY |-> PRDATA == 32'h0000_0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside answer");
    property p_rdata_upper;
        PREADY |-> PRDATA[31:8] == 24'h00_0000;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper read data set");
endmodule
bind cat_timer_control cat_timer_control_sva cat_timer_control_sva_inst
(
    .CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE, .PRDATA, .PREADY, .PSLVERR,
    .OVF_IRQ_REQ, .MODULE_IRQ_REQ, .IRQ
);

// ==== bench/testbench.sv ====
// self-checking bench of the counter array timer control
// assumes cat_pkg indices; the bench is the apb master and capture source
`timescale 1ns/1ps
module testbench;
    import cat_pkg::*;
    logic CLK_SYS, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, OVF_IRQ_REQ, IRQ;
    logic [ADDR_WIDTH-1:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic [3:0] PSTRB;
    logic [NUM_MODULES-1:0] MODULE_CAPTURE, MODULE_IRQ_REQ;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    cat_timer_control cat_timer_control_inst
    (
        .CLK_SYS, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PSTRB,
        .MODULE_CAPTURE, .PRDATA, .PREADY, .PSLVERR, .OVF_IRQ_REQ,
        .MODULE_IRQ_REQ, .IRQ
    );
    initial
    begin
        CLK_SYS = 1'b0;
        forever #25 CLK_SYS = ~CLK_SYS;
    end
    // ****
    // tasks
    // ****
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        cmp_count++;
        if (g !== x)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask
    // entered just after an edge; one idle cycle after release
    task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d,
        output logic [31:0] r, output logic e);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= {2'b00, i, 2'b00};
        PWDATA <= {24'h00_0000, d};
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        @(posedge CLK_SYS);
        while (PREADY !== 1'b1)
            @(posedge CLK_SYS);
        r = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK_SYS);
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask
    task automatic rd(input string n, input logic [7:0] i, input logic [7:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, i, 8'h00, r, e);
        chk(n, {24'h00_0000, x}, r);
    endtask
    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd("control", IDX_CONTROL, 8'h00);
        rd("low", IDX_COUNT_LOW, 8'h00);
        rd("high", IDX_COUNT_HIGH, 8'h00);
        // a write with lane 0 off must leave the byte alone
        PSTRB <= 4'h0;
        wr(IDX_COUNT_LOW, 8'h55);
        PSTRB <= 4'hf;
        rd("strobe off", IDX_COUNT_LOW, 8'h00);
        apb(1'b0, 8'h10, 8'h00, r, e);
        chk("unmapped err", 32'h0000_0001, {31'h0000_0000, e});
        $display("reset done");
    endtask
    task automatic t_count();
        wr(IDX_COUNT_LOW, 8'hff);
        wr(IDX_COUNT_HIGH, 8'h12);
        rd("halted low", IDX_COUNT_LOW, 8'hff);
        wr(IDX_CONTROL, 8'h40);
        wr(IDX_CONTROL, 8'h00);
        rd("carry high", IDX_COUNT_HIGH, 8'h13);
        $display("count done");
    endtask
    task automatic t_ovf();
        wr(IDX_ARRAY_MODE, 8'h01);
        wr(IDX_IRQ_MASK, 8'h01);
        wr(IDX_COUNT_LOW, 8'hff);
        wr(IDX_COUNT_HIGH, 8'hff);
        wr(IDX_CONTROL, 8'h40);
        rd("ovf flag", IDX_CONTROL, 8'hc0);
        rd("wrap high", IDX_COUNT_HIGH, 8'h00);
        rd("ovf event", IDX_IRQ_STATUS, 8'h01);
        chk("ovf req", 1, OVF_IRQ_REQ);
        chk("irq", 1, IRQ);
        wr(IDX_IRQ_MASK, 8'h00);
        @(posedge CLK_SYS);
        chk("masked irq", 0, IRQ);
        wr(IDX_CONTROL, 8'h00);
        wr(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_MASK, 8'h01);
        @(posedge CLK_SYS);
        chk("cleared req", 0, OVF_IRQ_REQ);
        chk("cleared irq", 0, IRQ);
        wr(IDX_CONTROL, 8'h80);
        @(posedge CLK_SYS);
        chk("sw set req", 1, OVF_IRQ_REQ);
        chk("sw set irq", 0, IRQ);
        wr(IDX_ARRAY_MODE, 8'h00);
        @(posedge CLK_SYS);
        chk("ovf disabled", 0, OVF_IRQ_REQ);
        wr(IDX_CONTROL, 8'h00);
        $display("overflow done");
    endtask
    task automatic t_capture();
        for (int x = 0; x < NUM_MODULES; x++)
        begin
            wr(IDX_MODULE_MODE0 + 8'(x), 8'h01);
            MODULE_CAPTURE <= NUM_MODULES'(1 << x);
            @(posedge CLK_SYS);
            MODULE_CAPTURE <= '0;
            repeat (2) @(posedge CLK_SYS);
            chk("module req", 32'((2 << x) - 1), 32'(MODULE_IRQ_REQ));
        end
        rd("module flags", IDX_CONTROL, 8'h1f);
        rd("module events", IDX_IRQ_STATUS, 8'h3e);
        wr(IDX_IRQ_MASK, 8'h20);
        @(posedge CLK_SYS);
        chk("module irq", 1, IRQ);
        wr(IDX_IRQ_STATUS, 8'h3e);
        wr(IDX_IRQ_MASK, 8'h01);
        @(posedge CLK_SYS);
        chk("module irq cleared", 0, IRQ);
        wr(IDX_MODULE_MODE0, 8'h00);
        @(posedge CLK_SYS);
        chk("req disabled", 32'h0000_001e, 32'(MODULE_IRQ_REQ));
        wr(IDX_CONTROL, 8'h00);
        @(posedge CLK_SYS);
        chk("req cleared", 0, 32'(MODULE_IRQ_REQ));
        $display("capture done");
    endtask
    task automatic t_match();
        wr(IDX_MODULE_MODE0, 8'h49);
        wr(IDX_MODULE_MODE0 + 8'h01, 8'h41);
        rd("mode0", IDX_MODULE_MODE0, 8'h49);
        wr(IDX_MODULE_MODE0 + 8'h02, 8'h81);
        rd("mode reserved", IDX_MODULE_MODE0 + 8'h02, 8'h01);
        wr(IDX_COMPARE_HIGH0 + 8'h04, 8'ha5);
        rd("cmp high", IDX_COMPARE_HIGH0 + 8'h04, 8'ha5);
        wr(IDX_COMPARE_LOW0, 8'h05);
        wr(IDX_COMPARE_LOW0 + 8'h01, 8'h05);
        wr(IDX_COUNT_LOW, 8'h00);
        wr(IDX_COUNT_HIGH, 8'h00);
        wr(IDX_CONTROL, 8'h40);
        repeat (20) @(posedge CLK_SYS);
        rd("match flag", IDX_CONTROL, 8'h41);
        chk("match req", 1, 32'(MODULE_IRQ_REQ));
        wr(IDX_CONTROL, 8'h00);
        $display("match done");
    endtask
    // ****
    // sequence and hang guard
    // ****
    always @(posedge CLK_SYS)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        NRST = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = '0;
        PWDATA = '0;
        PSTRB = 4'hf;
        MODULE_CAPTURE = '0;
        repeat (12) @(posedge CLK_SYS);
        NRST <= 1'b1;
        @(posedge CLK_SYS);
        t_reset();
        t_count();
        t_ovf();
        t_capture();
        t_match();
        complete_run();
    end
endmodule
